//--- hw/vsc_ctrl.sv
// controller that sequences strobe cycles into a dual-port video dram
`timescale 1ns/1ps
`include "vsc_defs.svh"
module vsc_ctrl #(
	parameter int ROW_W = `VSC_ROW_W,
	parameter int DQ_W  = `VSC_DQ_W
) (
	input  wire logic                mclk,
	input  wire logic                sys_rst,
	input  wire logic                req_valid,
	input  vsc_pkg::vsc_req_s        req,
	output logic                     req_ready,
	output logic                     req_error,
	output logic                     rd_valid,
	output logic [DQ_W-1:0]          rd_data,
	output logic                     old_mask_mode,
	output logic                     split_read_allowed,
	output logic                     split_write_allowed,
	output vsc_pkg::vsc_strobe_s     strb,
	output logic [ROW_W-1:0]         addr,
	output logic [DQ_W-1:0]          dq_out,
	output logic                     dq_oe_n,
	input  wire logic [DQ_W-1:0]     dq_in
);
	if (ROW_W != `VSC_ROW_W || DQ_W != `VSC_DQ_W) begin : g_bad_width
		$error("vsc_ctrl: unsupported widths");
	end

	// ------------------------------------------------------------
	// states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_SETUP = 3'b001,
		ST_ROW   = 3'b011,
		ST_COL   = 3'b010,
		ST_DONE  = 3'b110
	} vsc_state_e;

	vsc_state_e         state, next_state;
	vsc_pkg::vsc_req_s  cur, next_cur;
	logic [2:0]         cnt, next_cnt;
	logic               rt_done, next_rt_done;
	logic               mwt_done, next_mwt_done;
	logic               old_mask, next_old_mask;
	logic               bad, next_bad;
	logic               rvalid, next_rvalid;
	logic [DQ_W-1:0]    rdata, next_rdata;
	vsc_pkg::vsc_strobe_s s, next_s;
	logic [ROW_W-1:0]   a, next_a;
	logic [DQ_W-1:0]    dqo, next_dqo;
	logic               oen, next_oen;
	logic [DQ_W-1:0]    dq_s1, dq_s2;

	logic cbr, xfer_n, we_n, dsf_row, dsf_col, mask_at_row, legal;
	logic stop_ok, allowed;

	vsc_decode u_dec (
		.cmd         (state == ST_IDLE ? req.cmd : cur.cmd),
		.cbr         (cbr),
		.xfer_n      (xfer_n),
		.we_n        (we_n),
		.dsf_row     (dsf_row),
		.dsf_col     (dsf_col),
		.mask_at_row (mask_at_row),
		.legal       (legal)
	);

	// stop pattern must be a run of ones from bit 4 up
	always_comb begin
		case (req.row[`VSC_STOP_HI:`VSC_STOP_LO])
			4'hF, 4'h7, 4'h3, 4'h1, 4'h0: stop_ok = 1'b1;
			default:                      stop_ok = 1'b0;
		endcase
		allowed = legal;
		if (req.cmd == vsc_pkg::VSC_CMD_SPLIT_READ && !rt_done)
			allowed = 1'b0;
		if (req.cmd == vsc_pkg::VSC_CMD_SPLIT_WXFER && !mwt_done)
			allowed = 1'b0;
		if (req.cmd == vsc_pkg::VSC_CMD_SET_STOP && !stop_ok)
			allowed = 1'b0;
	end

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	always_comb begin
		next_state    = state;
		next_cur      = cur;
		next_cnt      = cnt;
		next_rt_done  = rt_done;
		next_mwt_done = mwt_done;
		next_old_mask = old_mask;
		next_bad      = 1'b0;
		next_rvalid   = 1'b0;
		next_rdata    = rdata;
		next_s        = s;
		next_a        = a;
		next_dqo      = dqo;
		next_oen      = oen;
		case (state)
			ST_IDLE: begin
				if (req_valid) begin
					if (allowed) begin
						next_cur   = req;
						next_state = ST_SETUP;
						next_cnt   = 3'(`VSC_SETUP_CYC);
						next_s.column_strobe_n          = ~cbr;
						next_s.transfer_output_enable_n = xfer_n;
						next_s.write_mask_enable_n      = we_n;
						next_s.special_function_select  = dsf_row;
						next_a   = req.row;
						// mask rides the data pins at the row fall; old-mask mode ignores it
						next_dqo = req.mask;
						next_oen = ~mask_at_row;
					end else begin
						next_bad = 1'b1;
					end
				end
			end
			ST_SETUP: begin
				next_cnt = cnt - 3'd1;
				if (cnt == 3'd1) begin
					next_s.row_strobe_n = 1'b0;
					next_state = ST_ROW;
					next_cnt   = 3'(`VSC_STROBE_CYC);
				end
			end
			ST_ROW: begin
				next_cnt = cnt - 3'd1;
				if (cnt == 3'd2 && !cbr) begin
					// column phase: start tap, block column, or write data
					next_a = cur.col;
					next_s.special_function_select  = dsf_col;
					// register read picks mask or colour through the column-fall select
					if (cur.cmd == vsc_pkg::VSC_CMD_READ_REG)
						next_s.special_function_select = cur.reg_sel;
					next_s.transfer_output_enable_n =
						(cur.cmd == vsc_pkg::VSC_CMD_READ_REG) ? 1'b0 : 1'b1;
					// writes and register loads need write enable low at the column fall
					next_s.write_mask_enable_n =
						(cur.cmd == vsc_pkg::VSC_CMD_READ_REG) ? 1'b1
						: (!xfer_n) ? we_n : 1'b0;
					next_dqo = (cur.cmd == vsc_pkg::VSC_CMD_READ_REG) ? {DQ_W{1'b0}}
						: (dsf_col ? cur.mask : cur.data);
					next_oen = (cur.cmd == vsc_pkg::VSC_CMD_READ_REG ||
						cur.cmd == vsc_pkg::VSC_CMD_READ_XFER ||
						cur.cmd == vsc_pkg::VSC_CMD_SPLIT_READ);
				end
				if (cnt == 3'd1) begin
					if (!cbr)
						next_s.column_strobe_n = 1'b0;
					next_state = ST_COL;
					next_cnt   = 3'(`VSC_STROBE_CYC);
				end
			end
			ST_COL: begin
				next_cnt = cnt - 3'd1;
				if (cnt == 3'd1) begin
					if (cur.cmd == vsc_pkg::VSC_CMD_READ_REG) begin
						next_rvalid = 1'b1;
						next_rdata  = dq_s2;
					end
					next_s   = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
					next_oen = 1'b1;
					next_state = ST_DONE;
				end
			end
			ST_DONE: begin
				case (cur.cmd)
					vsc_pkg::VSC_CMD_READ_XFER:  next_rt_done  = 1'b1;
					vsc_pkg::VSC_CMD_MASK_WXFER: next_mwt_done = 1'b1;
					vsc_pkg::VSC_CMD_LOAD_MASK:  next_old_mask = 1'b1;
					vsc_pkg::VSC_CMD_RESET_OPT:  next_old_mask = 1'b0;
					default:                     next_old_mask = old_mask;
				endcase
				next_state = ST_IDLE;
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		dq_s1 <= dq_in;
		dq_s2 <= dq_s1;
		if (sys_rst) begin
			state    <= ST_IDLE;
			cur      <= '0;
			cnt      <= 3'h0;
			rt_done  <= 1'b0;
			mwt_done <= 1'b0;
			old_mask <= 1'b0;
			bad      <= 1'b0;
			rvalid   <= 1'b0;
			rdata    <= '0;
			s        <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
			a        <= '0;
			dqo      <= '0;
			oen      <= 1'b1;
		end else begin
			state    <= next_state;
			cur      <= next_cur;
			cnt      <= next_cnt;
			rt_done  <= next_rt_done;
			mwt_done <= next_mwt_done;
			old_mask <= next_old_mask;
			bad      <= next_bad;
			rvalid   <= next_rvalid;
			rdata    <= next_rdata;
			s        <= next_s;
			a        <= next_a;
			dqo      <= next_dqo;
			oen      <= next_oen;
		end
	end

	// ------------------------------------------------------------
	// outputs, all registered
	// ------------------------------------------------------------
	logic rdy_q;
	always_ff @(posedge mclk) begin
		if (sys_rst)
			rdy_q <= 1'b0;
		else
			rdy_q <= (next_state == ST_IDLE);
	end
	assign req_ready           = rdy_q;
	assign req_error           = bad;
	assign rd_valid            = rvalid;
	assign rd_data             = rdata;
	assign old_mask_mode       = old_mask;
	assign split_read_allowed  = rt_done;
	assign split_write_allowed = mwt_done;
	assign strb                = s;
	assign addr                = a;
	assign dq_out              = dqo;
	assign dq_oe_n             = oen;
endmodule : vsc_ctrl

//--- hw/vsc_defs.svh
// constants for the video dram cycle sequencer
`ifndef VSC_DEFS_SVH
`define VSC_DEFS_SVH
`define VSC_ROW_W        9
`define VSC_COL_W        9
`define VSC_DQ_W         8
`define VSC_COL_MSB      8
`define VSC_STOP_LO      4
`define VSC_STOP_HI      7
`define VSC_STOP_DEFAULT 4'hF
`define VSC_T_SETUP_NS   100
`define VSC_T_STROBE_NS  150
`define VSC_CLK_NS       50
`define VSC_SETUP_CYC    ((`VSC_T_SETUP_NS + `VSC_CLK_NS - 1) / `VSC_CLK_NS)
`define VSC_STROBE_CYC   ((`VSC_T_STROBE_NS + `VSC_CLK_NS - 1) / `VSC_CLK_NS)
`endif

//--- hw/vsc_pkg.sv
// types for the video dram cycle sequencer
package vsc_pkg;
	typedef enum logic [3:0] {
		VSC_CMD_NONE        = 4'h0,
		VSC_CMD_READ_XFER   = 4'h1,
		VSC_CMD_SPLIT_READ  = 4'h2,
		VSC_CMD_MASK_WXFER  = 4'h3,
		VSC_CMD_SPLIT_WXFER = 4'h4,
		VSC_CMD_SET_STOP    = 4'h5,
		VSC_CMD_RESET_OPT   = 4'h6,
		VSC_CMD_WRITE       = 4'h7,
		VSC_CMD_MASK_WRITE  = 4'h8,
		VSC_CMD_BLOCK       = 4'h9,
		VSC_CMD_MASK_BLOCK  = 4'hA,
		VSC_CMD_FLASH       = 4'hB,
		VSC_CMD_LOAD_MASK   = 4'hC,
		VSC_CMD_LOAD_COLOR  = 4'hD,
		VSC_CMD_READ_REG    = 4'hE
	} vsc_cmd_e;
	typedef struct packed {
		vsc_cmd_e    cmd;
		logic [8:0]  row;
		logic [8:0]  col;
		logic [7:0]  mask;
		logic [7:0]  data;
		logic        reg_sel;
	} vsc_req_s;
	typedef struct packed {
		logic        row_strobe_n;
		logic        column_strobe_n;
		logic        transfer_output_enable_n;
		logic        write_mask_enable_n;
		logic        special_function_select;
	} vsc_strobe_s;
endpackage : vsc_pkg

//--- hw/vsc_decode.sv
// maps a command to the strobe levels sampled at the row and column strobe falls
`timescale 1ns/1ps
module vsc_decode (
	input  vsc_pkg::vsc_cmd_e  cmd,
	output logic               cbr,
	output logic               xfer_n,
	output logic               we_n,
	output logic               dsf_row,
	output logic               dsf_col,
	output logic               mask_at_row,
	output logic               legal
);
	always_comb begin
		cbr         = 1'b0;
		xfer_n      = 1'b1;
		we_n        = 1'b1;
		dsf_row     = 1'b0;
		dsf_col     = 1'b0;
		mask_at_row = 1'b0;
		legal       = 1'b1;
		case (cmd)
			vsc_pkg::VSC_CMD_READ_XFER: begin
				xfer_n = 1'b0;
			end
			vsc_pkg::VSC_CMD_SPLIT_READ: begin
				xfer_n  = 1'b0;
				dsf_row = 1'b1;
			end
			vsc_pkg::VSC_CMD_MASK_WXFER: begin
				xfer_n      = 1'b0;
				we_n        = 1'b0;
				mask_at_row = 1'b1;
			end
			vsc_pkg::VSC_CMD_SPLIT_WXFER: begin
				xfer_n      = 1'b0;
				we_n        = 1'b0;
				dsf_row     = 1'b1;
				mask_at_row = 1'b1;
			end
			vsc_pkg::VSC_CMD_SET_STOP: begin
				cbr     = 1'b1;
				we_n    = 1'b0;
				dsf_row = 1'b1;
			end
			vsc_pkg::VSC_CMD_RESET_OPT: begin
				cbr = 1'b1;
			end
			vsc_pkg::VSC_CMD_WRITE: begin
				we_n = 1'b1;
			end
			vsc_pkg::VSC_CMD_MASK_WRITE: begin
				we_n        = 1'b0;
				mask_at_row = 1'b1;
			end
			vsc_pkg::VSC_CMD_BLOCK: begin
				dsf_col = 1'b1;
			end
			vsc_pkg::VSC_CMD_MASK_BLOCK: begin
				we_n        = 1'b0;
				dsf_col     = 1'b1;
				mask_at_row = 1'b1;
			end
			vsc_pkg::VSC_CMD_FLASH: begin
				we_n        = 1'b0;
				dsf_row     = 1'b1;
				mask_at_row = 1'b1;
			end
			vsc_pkg::VSC_CMD_LOAD_MASK: begin
				dsf_row = 1'b1;
			end
			vsc_pkg::VSC_CMD_LOAD_COLOR: begin
				dsf_row = 1'b1;
				dsf_col = 1'b1;
			end
			vsc_pkg::VSC_CMD_READ_REG: begin
				dsf_row = 1'b0;
			end
			default: begin
				legal = 1'b0;
			end
		endcase
	end
endmodule : vsc_decode

//--- sim/vsc_ctrl_asserts.sv
// assertions on the strobe sequencer ports
`timescale 1ns/1ps
module vsc_ctrl_asserts (
	input wire logic            mclk,
	input wire logic            sys_rst,
	input wire logic            req_ready,
	input wire logic            req_error,
	input wire logic            rd_valid,
	input wire logic            split_read_allowed,
	input wire logic            split_write_allowed,
	input vsc_pkg::vsc_strobe_s strb,
	input wire logic [8:0]      addr,
	input wire logic            dq_oe_n
);
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	logic rn;
	logic x;
	logic w;
	logic f;
	assign rn = strb.row_strobe_n;
	assign x = !strb.transfer_output_enable_n && strb.column_strobe_n;
	assign w = strb.write_mask_enable_n;
	assign f = strb.special_function_select;
	property p_err; req_error |-> rn [*3]; endproperty
	a_err: assert property (p_err) else $error("strobes on refused command");
	property p_epl; req_error |=> !req_error; endproperty
	a_epl: assert property (p_epl) else $error("error not a pulse");
	property p_rpl; rd_valid |=> !rd_valid; endproperty
	a_rpl: assert property (p_rpl) else $error("read valid not a pulse");
	property p_idle; req_ready |-> rn && strb.column_strobe_n; endproperty
	a_idle: assert property (p_idle) else $error("strobe low while idle");
	property p_srt; $fell(rn) && x && w && f |-> split_read_allowed; endproperty
	a_srt: assert property (p_srt) else $error("split read without full read");
	property p_swt; $fell(rn) && x && !w && f |-> split_write_allowed; endproperty
	a_swt: assert property (p_swt) else $error("split write without masked write");
	property p_mwt; $fell(rn) && x && !w && !f |-> !dq_oe_n; endproperty
	a_mwt: assert property (p_mwt) else $error("no mask driven at transfer");
	property p_rt; $fell(rn) && x && w && !f |-> ##[1:10] split_read_allowed; endproperty
	a_rt: assert property (p_rt) else $error("full read not recorded");
	property p_stop;
		$fell(rn) && !strb.column_strobe_n && !w && f
			|-> addr[7:4] inside {4'hF, 4'h7, 4'h3, 4'h1, 4'h0};
	endproperty
	a_stop: assert property (p_stop) else $error("inhibited stop pattern sent");
endmodule : vsc_ctrl_asserts
bind vsc_ctrl vsc_ctrl_asserts u_vsc_ctrl_asserts (.mclk, .sys_rst, .req_ready, .req_error,
	.rd_valid, .split_read_allowed, .split_write_allowed, .strb, .addr, .dq_oe_n);

//--- sim/vsc_dev_model.sv
// behavioural video dram register side, reacting to strobe edges
`timescale 1ns/1ps
module vsc_dev_model (
	input vsc_pkg::vsc_strobe_s strb,
	input wire logic [8:0]      addr,
	input wire logic [7:0]      dq_out,
	input wire logic            dq_oe_n,
	output logic [7:0]          dq_in
);
	logic [7:0] mask_reg = 8'h00;
	logic [7:0] color_reg = 8'h00;
	logic [7:0] last = 8'h00;
	logic [3:0] stop_reg = 4'hF;
	logic       old_mask = 1'b0;
	logic       rd_cyc = 1'b0;
	logic       rd_sel, xf, wr, fr;
	logic       serial_clock = 1'b0;
	logic       port_in = 1'b0;
	logic       half_flag = 1'b0;
	logic       loaded = 1'b0;
	logic       pend_ok = 1'b0;
	logic [8:0] ptr = 9'h000;
	logic [8:0] pend = 9'h000;
	logic [3:0] stop_act = 4'hF;
	logic       part_end;
	// serial side runs free, as a display would shift it
	always #40 serial_clock = ~serial_clock;
	assign part_end = &ptr[3:0] && &(ptr[7:4] | ~stop_act);
	always @(posedge serial_clock) begin
		if (loaded) begin
			if (pend_ok && part_end) begin
				ptr = pend;
				pend_ok = 1'b0;
			end else
				ptr = ptr + 9'h001;
		end
	end
	always @(negedge strb.row_strobe_n) begin
		xf = !strb.transfer_output_enable_n;
		wr = strb.write_mask_enable_n;
		fr = strb.special_function_select;
		if (!strb.column_strobe_n && fr && !wr)
			stop_reg = addr[7:4];
		else if (!strb.column_strobe_n && !fr) begin
			stop_reg = 4'hF;
			stop_act = 4'hF;
			old_mask = 1'b0;
		end
	end
	always @(negedge strb.column_strobe_n) begin
		if (!strb.row_strobe_n && !xf) begin
			if (wr && fr && !dq_oe_n && !strb.write_mask_enable_n && strb.special_function_select)
				color_reg = dq_out;
			else if (wr && fr && !dq_oe_n && !strb.write_mask_enable_n) begin
				mask_reg = dq_out;
				old_mask = 1'b1;
			end
			rd_cyc = dq_oe_n;
			rd_sel = strb.special_function_select;
		end else if (!strb.row_strobe_n) begin
			if (!fr) begin
				ptr = addr;
				half_flag = addr[8];
				port_in = !wr;
				loaded = 1'b1;
				pend_ok = 1'b0;
			end else begin
				// only the idle half is loaded; a later split overwrites an earlier one
				pend = {~ptr[8], addr[7:0]};
				pend_ok = 1'b1;
				if (wr)
					stop_act = stop_reg;
			end
		end
	end
	// released pins show a changed value so a stale sample cannot pass
	always @(posedge strb.column_strobe_n) begin
		last = dq_in;
		rd_cyc = 1'b0;
	end
	assign dq_in = rd_cyc ? (rd_sel ? color_reg : mask_reg) : ~last;
endmodule : vsc_dev_model

//--- sim/vsc_ctrl_bench.sv
// self-checking bench for the strobe sequencer
`timescale 1ns/1ps
module vsc_ctrl_bench;
	logic                 mclk = 1'b0;
	logic                 sys_rst = 1'b1;
	logic                 req_valid = 1'b0;
	vsc_pkg::vsc_req_s    req = '0;
	vsc_pkg::vsc_strobe_s strb;
	logic                 req_ready, req_error, rd_valid, old_mask_mode, dq_oe_n;
	logic                 split_read_allowed, split_write_allowed;
	logic [8:0]           addr;
	logic [7:0]           dq_out, dq_in, rd_data, mv, cv;
	logic [3:0]           pats [6] = '{4'hF, 4'h7, 4'h3, 4'h1, 4'h0, 4'h5};
	int                   err_total = 0, compares = 0, cyc = 0;
	logic                 rd_ok = 1'b0, wr_ok = 1'b0, om = 1'b0, pin = 1'b0, hf = 1'b0;
	logic [7:0]           mreg = 8'h00, creg = 8'h00;
	always #25 mclk = ~mclk;
	vsc_ctrl u_vsc_ctrl (.mclk, .sys_rst, .req_valid, .req, .req_ready, .req_error, .rd_valid,
		.rd_data, .old_mask_mode, .split_read_allowed, .split_write_allowed, .strb, .addr,
		.dq_out, .dq_oe_n, .dq_in);
	vsc_dev_model u_vsc_dev_model (.strb, .addr, .dq_out, .dq_oe_n, .dq_in);
	task automatic chk(input logic [7:0] g, input logic [7:0] x);
		compares++;
		if (g !== x) begin
			err_total++;
			$display("ERROR %0t: got %h expected %h", $time, g, x);
		end
	endtask : chk
	task automatic final_report;
		if (err_total == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : final_report
	// offer one command, then collect its pulses until the sequencer is idle again
	task automatic go(input vsc_pkg::vsc_cmd_e c, input logic [8:0] r, input logic [7:0] d,
			input logic s);
		logic       e, v, xe;
		logic [7:0] q;
		e = 0;
		v = 0;
		q = 0;
		while (!req_ready) begin
			@(posedge mclk);
			#1;
		end
		req_valid = 1;
		req = '{c, r, 9'($urandom), d, d, s};
		@(posedge mclk);
		#1 req_valid = 0;
		for (int n = 0; n < 30 && !(req_ready && n > 1); n++) begin
			e |= req_error;
			if (rd_valid) begin
				v = 1;
				q = rd_data;
			end
			@(posedge mclk);
			#1;
		end
		case (c)
			vsc_pkg::VSC_CMD_NONE: xe = 1;
			vsc_pkg::VSC_CMD_SPLIT_READ: xe = !rd_ok;
			vsc_pkg::VSC_CMD_SPLIT_WXFER: xe = !wr_ok;
			vsc_pkg::VSC_CMD_SET_STOP: xe = !(r[7:4] inside {4'hF, 4'h7, 4'h3, 4'h1, 4'h0});
			default: xe = 0;
		endcase
		if (!xe) case (c)
			vsc_pkg::VSC_CMD_READ_XFER: begin
				rd_ok = 1'b1;
				pin   = 1'b0;
				hf    = req.col[8];
			end
			vsc_pkg::VSC_CMD_MASK_WXFER: begin
				wr_ok = 1'b1;
				pin   = 1'b1;
				hf    = req.col[8];
			end
			vsc_pkg::VSC_CMD_LOAD_MASK: begin
				om = 1;
				mreg = d;
			end
			vsc_pkg::VSC_CMD_LOAD_COLOR: creg = d;
			vsc_pkg::VSC_CMD_RESET_OPT: om = 0;
			default: ;
		endcase
		chk(e, xe);
		chk(old_mask_mode, om);
		chk(split_read_allowed, rd_ok);
		chk(split_write_allowed, wr_ok);
		chk(u_vsc_dev_model.port_in, pin);
		chk(u_vsc_dev_model.half_flag, hf);
		if (c == vsc_pkg::VSC_CMD_READ_REG) begin
			chk(v, 8'h01);
			chk(q, s ? creg : mreg);
		end
	endtask : go
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			$display("ERROR %0t: run did not finish", $time);
			final_report;
		end
	end
	initial begin
		mv = 8'($urandom(32'hD08231D6));
		repeat (10) @(posedge mclk);
		#1 sys_rst = 0;
		repeat (2) @(posedge mclk);
		#1;
		chk(old_mask_mode, 0);
		go(vsc_pkg::VSC_CMD_SPLIT_READ, 9'($urandom), 0, 0);
		go(vsc_pkg::VSC_CMD_SPLIT_WXFER, 9'($urandom), 8'($urandom), 0);
		go(vsc_pkg::VSC_CMD_READ_XFER, 9'($urandom), 0, 0);
		repeat (2) go(vsc_pkg::VSC_CMD_SPLIT_READ, 9'($urandom), 0, 0);
		go(vsc_pkg::VSC_CMD_MASK_WXFER, 9'($urandom), 8'($urandom), 0);
		go(vsc_pkg::VSC_CMD_SPLIT_WXFER, 9'($urandom), 8'($urandom), 0);
		foreach (pats[i]) go(vsc_pkg::VSC_CMD_SET_STOP, {1'b1, pats[i], 4'($urandom)}, 0, 0);
		go(vsc_pkg::VSC_CMD_RESET_OPT, 0, 0, 0);
		for (int i = 7; i <= 11; i++) go(vsc_pkg::vsc_cmd_e'(i), 9'($urandom), 8'($urandom), 0);
		mv = 8'($urandom);
		cv = 8'($urandom);
		go(vsc_pkg::VSC_CMD_LOAD_MASK, 9'($urandom), mv, 0);
		go(vsc_pkg::VSC_CMD_LOAD_COLOR, 9'($urandom), cv, 1);
		go(vsc_pkg::VSC_CMD_MASK_WRITE, 9'($urandom), 8'($urandom), 0);
		go(vsc_pkg::VSC_CMD_READ_REG, 0, 0, 0);
		go(vsc_pkg::VSC_CMD_READ_REG, 0, 0, 1);
		go(vsc_pkg::VSC_CMD_RESET_OPT, 0, 0, 0);
		go(vsc_pkg::VSC_CMD_NONE, 0, 0, 0);
		final_report;
	end
endmodule : vsc_ctrl_bench
